/* design/ast_pkg.sv */
// Purpose: shared constants and types for the serial converter link
// Assumes: 50 MHz reference clock on both ends
// Notes: qualification, conversion and end-of-conversion counts derive from nanosecond figures
package ast_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RES_W = 10;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 5;
  // chip-select qualification: setup plus two internal clock edges
  localparam int CS_QUAL_NS = 1425;
  localparam int CS_QUAL_CYC = (CS_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest conversion time, rounded down
  localparam int CONV_NS = 21000;
  localparam int CONV_CYC = CONV_NS / CLK_PERIOD_NS;
  // tenth falling shift edge to end-of-conversion low, longest
  localparam int EOC_FALL_NS = 240;
  localparam int EOC_FALL_CYC =
    (EOC_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 3;
  // host shift clock half period, 80 ns full period
  localparam int IO_HALF_CYC = 2;
  localparam logic [CNT_W-1:0] XFER_SHORT = 5'h0a;
  localparam logic [CNT_W-1:0] XFER_MIN = 5'h0b;
  localparam logic [CNT_W-1:0] XFER_MAX = 5'h10;
  localparam logic [CNT_W-1:0] ACQ_FIRST = 5'h04;
  localparam logic [CNT_W-1:0] ADDR_LAST = 5'h04;
  localparam logic [3:0] MSB_IDX = 4'h9;
  localparam logic [ADDR_W-1:0] SELF_MID = 4'hb;
  localparam logic [ADDR_W-1:0] SELF_ZERO = 4'hc;
  localparam logic [ADDR_W-1:0] SELF_FULL = 4'hd;
  localparam logic [RES_W-1:0] CODE_MID = 10'h200;
  localparam logic [RES_W-1:0] CODE_ZERO = 10'h000;
  localparam logic [RES_W-1:0] CODE_FULL = 10'h3ff;
  localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
  typedef enum logic {AST_CV_IDLE, AST_CV_BUSY} ast_conv_t;
  typedef enum logic [2:0] {
    AST_H_IDLE, AST_H_SETUP, AST_H_WAIT_EOC, AST_H_LOW, AST_H_HIGH,
    AST_H_END
  } ast_host_t;
endpackage

/* design/ast_link_if.sv */
// Purpose: four-wire serial link plus end-of-conversion line
// Assumes: host makes chip select, shift clock and address
// Notes: data output enable marks when the device drives the line
`timescale 1ns/1ps
`default_nettype none
interface ast_link_if;
  logic csN;
  logic ioClk;
  logic addrBit;
  logic dataOut;
  logic dataOutEn;
  logic eoc;
  modport device (
    input csN,
    input ioClk,
    input addrBit,
    output dataOut,
    output dataOutEn,
    output eoc
  );
  modport host (
    output csN,
    output ioClk,
    output addrBit,
    input dataOut,
    input dataOutEn,
    input eoc
  );
endinterface
`default_nettype wire

/* design/ast_device.sv */
// Purpose: converter end of the serial link, sequencing and conversion
// Assumes: shift clock is a second domain; analog value arrives digitised
// Notes: conversion itself is a timed hold of a sampled value
`timescale 1ns/1ps
`default_nettype none
module ast_device #(
  parameter int unsigned QUAL_CYC = ast_pkg::CS_QUAL_CYC,
  parameter int unsigned CONV_CYC = ast_pkg::CONV_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  ast_link_if.device link,
  input wire logic [ast_pkg::RES_W-1:0] convValue,
  output logic [ast_pkg::ADDR_W-1:0] chanSel,
  output logic sampleWin,
  output logic [ast_pkg::RES_W-1:0] lastResult,
  output logic convBusy
);
  localparam int QW = $clog2(QUAL_CYC + 1);
  localparam int CW = $clog2(CONV_CYC + 1);
  localparam logic [QW-1:0] QUAL_LAST = QW'(QUAL_CYC - 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);

  // reference domain state
  logic csS1_r, csS2_r, csS3_r;
  logic csActive_r, csActive_nxt;
  logic [QW-1:0] qualCnt_r, qualCnt_nxt;
  logic tglS1_r, tglS2_r, tglS3_r;
  ast_pkg::ast_conv_t state_r, state_nxt;
  logic [CW-1:0] convCnt_r, convCnt_nxt;
  logic eoc_r, eoc_nxt;
  logic [ast_pkg::RES_W-1:0] result_r, result_nxt;
  logic [ast_pkg::RES_W-1:0] sample_r, sample_nxt;
  logic [ast_pkg::ADDR_W-1:0] selAddr_r, selAddr_nxt;
  logic linkHold_r, linkHold_nxt;

  // link domain state
  logic [ast_pkg::CNT_W-1:0] riseCnt_r;
  logic [ast_pkg::CNT_W-1:0] fallCnt_r;
  logic [ast_pkg::ADDR_W-1:0] addrShift_r;
  logic convTgl_r;

  // chip select qualification
  wire csAgree = csS2_r == csS3_r;
  wire csLowNow = ~csS3_r;
  wire csDiffers = csAgree && (csLowNow != csActive_r);
  wire qualDone = csDiffers && (qualCnt_r == QUAL_LAST);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      csS1_r <= 1'b1;
      csS2_r <= 1'b1;
      csS3_r <= 1'b1;
      tglS1_r <= 1'b0;
      tglS2_r <= 1'b0;
      tglS3_r <= 1'b0;
    end else if (clkEn) begin
      csS1_r <= link.csN;
      csS2_r <= csS1_r;
      csS3_r <= csS2_r;
      tglS1_r <= convTgl_r;
      tglS2_r <= tglS1_r;
      tglS3_r <= tglS2_r;
    end
  end

  // a short glitch restarts the count, so noise never flips the level
  always_comb begin
    qualCnt_nxt = '0;
    csActive_nxt = csActive_r;
    if (csDiffers) begin
      qualCnt_nxt = qualCnt_r + 1'b1;
    end
    if (qualDone) begin
      qualCnt_nxt = '0;
      csActive_nxt = csLowNow;
    end
  end

  // conversion sequencing
  wire startEv = (tglS2_r ^ tglS3_r) && csActive_r;
  wire convLast = convCnt_r == CONV_LAST;
  wire isMid = selAddr_r == ast_pkg::SELF_MID;
  wire isZero = selAddr_r == ast_pkg::SELF_ZERO;
  wire isFull = selAddr_r == ast_pkg::SELF_FULL;
  wire [ast_pkg::RES_W-1:0] convCode =
    isMid ? ast_pkg::CODE_MID :
    isZero ? ast_pkg::CODE_ZERO :
    isFull ? ast_pkg::CODE_FULL : sample_r;

  always_comb begin
    state_nxt = state_r;
    convCnt_nxt = convCnt_r;
    eoc_nxt = eoc_r;
    result_nxt = result_r;
    sample_nxt = sample_r;
    selAddr_nxt = selAddr_r;
    case (state_r)
      ast_pkg::AST_CV_IDLE: begin
        if (startEv) begin
          // address stays still once the fourth bit is in
          selAddr_nxt = addrShift_r;
          sample_nxt = convValue;
          convCnt_nxt = '0;
          eoc_nxt = 1'b0;
          state_nxt = ast_pkg::AST_CV_BUSY;
        end
      end
      ast_pkg::AST_CV_BUSY: begin
        if (convLast) begin
          result_nxt = convCode;
          eoc_nxt = 1'b1;
          state_nxt = ast_pkg::AST_CV_IDLE;
        end else begin
          convCnt_nxt = convCnt_r + 1'b1;
        end
      end
      default: state_nxt = ast_pkg::AST_CV_IDLE;
    endcase
  end

  // one flop drives the link clear so it cannot glitch
  assign linkHold_nxt = ~csActive_nxt ||
    (state_nxt == ast_pkg::AST_CV_BUSY);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      csActive_r <= 1'b0;
      qualCnt_r <= '0;
      state_r <= ast_pkg::AST_CV_IDLE;
      convCnt_r <= '0;
      eoc_r <= 1'b1;
      result_r <= ast_pkg::RESULT_RST;
      sample_r <= ast_pkg::RESULT_RST;
      selAddr_r <= '0;
      linkHold_r <= 1'b1;
    end else if (clkEn) begin
      csActive_r <= csActive_nxt;
      qualCnt_r <= qualCnt_nxt;
      state_r <= state_nxt;
      convCnt_r <= convCnt_nxt;
      eoc_r <= eoc_nxt;
      result_r <= result_nxt;
      sample_r <= sample_nxt;
      selAddr_r <= selAddr_nxt;
      linkHold_r <= linkHold_nxt;
    end
  end

  // link domain: held clear until select qualifies and while converting
  wire addrTake = riseCnt_r < ast_pkg::ADDR_LAST;
  wire riseSat = riseCnt_r == ast_pkg::XFER_SHORT;
  wire fallSat = fallCnt_r == ast_pkg::XFER_SHORT;
  wire lastFall = fallCnt_r == ast_pkg::XFER_SHORT - 5'h01;

  // clkEn in this domain is assumed quasi-static
  always_ff @(posedge link.ioClk or posedge linkHold_r) begin
    if (linkHold_r) begin
      riseCnt_r <= '0;
      addrShift_r <= '0;
    end else if (clkEn) begin
      if (addrTake) begin
        addrShift_r <= {addrShift_r[ast_pkg::ADDR_W-2:0], link.addrBit};
      end
      if (!riseSat) begin
        riseCnt_r <= riseCnt_r + 1'b1;
      end
    end
  end

  // pulses past the tenth are ignored until conversion completes
  always_ff @(negedge link.ioClk or posedge linkHold_r) begin
    if (linkHold_r) begin
      fallCnt_r <= '0;
    end else if (clkEn && !fallSat) begin
      fallCnt_r <= fallCnt_r + 1'b1;
    end
  end

  // toggle survives the link clear, so the start event is not lost
  always_ff @(negedge link.ioClk or posedge reset) begin
    if (reset) begin
      convTgl_r <= 1'b0;
    end else if (clkEn && !linkHold_r && lastFall) begin
      convTgl_r <= ~convTgl_r;
    end
  end

  // result is only updated while the link is held, so reads are stable
  wire [3:0] bitIdx = ast_pkg::MSB_IDX - fallCnt_r[3:0];
  wire bitLive = !linkHold_r && !fallSat;
  assign link.dataOut = bitLive ? result_r[bitIdx] : 1'b0;
  assign link.dataOutEn = csActive_r;
  assign link.eoc = eoc_r;
  assign sampleWin = !linkHold_r && (fallCnt_r >= ast_pkg::ACQ_FIRST) &&
    !fallSat;
  assign chanSel = addrShift_r;
  assign lastResult = result_r;
  assign convBusy = state_r == ast_pkg::AST_CV_BUSY;
endmodule
`default_nettype wire

/* design/ast_host.sv */
// Purpose: host serial port driving the converter link
// Assumes: shift clock made here by dividing the reference clock
// Notes: result returned is the previous conversion's code
`timescale 1ns/1ps
`default_nettype none
module ast_host #(
  parameter int unsigned HALF_CYC = ast_pkg::IO_HALF_CYC,
  parameter int unsigned SETUP_CYC = ast_pkg::CS_QUAL_CYC +
    ast_pkg::SYNC_CYC + 1,
  parameter int unsigned EOC_WAIT_CYC = ast_pkg::EOC_FALL_CYC +
    ast_pkg::SYNC_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  ast_link_if.host link,
  input wire logic start,
  input wire logic [ast_pkg::ADDR_W-1:0] addrIn,
  input wire logic [ast_pkg::CNT_W-1:0] clkCount,
  input wire logic useCs,
  output logic ready,
  output logic [ast_pkg::RES_W-1:0] result,
  output logic resultValid
);
  localparam int TW = $clog2(SETUP_CYC + EOC_WAIT_CYC + HALF_CYC + 1);
  localparam logic [TW-1:0] HALF_LAST = TW'(HALF_CYC - 1);
  localparam logic [TW-1:0] SETUP_LAST = TW'(SETUP_CYC - 1);
  localparam logic [TW-1:0] EOC_LAST = TW'(EOC_WAIT_CYC - 1);

  ast_pkg::ast_host_t state_r, state_nxt;
  logic [TW-1:0] timer_r, timer_nxt;
  logic csN_r, csN_nxt;
  logic ioClk_r, ioClk_nxt;
  logic [ast_pkg::ADDR_W-1:0] addrSh_r, addrSh_nxt;
  logic addrBit_r, addrBit_nxt;
  logic [ast_pkg::CNT_W-1:0] pulse_r, pulse_nxt;
  logic [ast_pkg::CNT_W-1:0] target_r, target_nxt;
  logic useCs_r, useCs_nxt;
  logic [ast_pkg::RES_W-1:0] rx_r, rx_nxt;
  logic [ast_pkg::RES_W-1:0] result_r, result_nxt;
  logic valid_r, valid_nxt;
  logic eocS1_r, eocS2_r, eocS3_r;
  logic datS1_r, datS2_r, datS3_r;

  // toggled select: 11..16 pulses; held low: 10 or exactly 16
  wire [ast_pkg::CNT_W-1:0] csCnt =
    (clkCount < ast_pkg::XFER_MIN) ? ast_pkg::XFER_MIN :
    (clkCount > ast_pkg::XFER_MAX) ? ast_pkg::XFER_MAX : clkCount;
  wire [ast_pkg::CNT_W-1:0] heldCnt = (clkCount >= ast_pkg::XFER_MAX) ?
    ast_pkg::XFER_MAX : ast_pkg::XFER_SHORT;
  wire [ast_pkg::CNT_W-1:0] legalCnt = useCs ? csCnt : heldCnt;
  wire timerHalf = timer_r == HALF_LAST;
  wire eocHigh = eocS2_r && eocS3_r;
  wire lastPulse = (pulse_r + 5'h01) == target_r;
  wire rxTake = pulse_r < ast_pkg::XFER_SHORT;

  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r + 1'b1;
    csN_nxt = csN_r;
    ioClk_nxt = ioClk_r;
    addrSh_nxt = addrSh_r;
    addrBit_nxt = addrBit_r;
    pulse_nxt = pulse_r;
    target_nxt = target_r;
    useCs_nxt = useCs_r;
    rx_nxt = rx_r;
    result_nxt = result_r;
    valid_nxt = 1'b0;
    case (state_r)
      ast_pkg::AST_H_IDLE: begin
        timer_nxt = '0;
        if (start) begin
          addrSh_nxt = addrIn;
          target_nxt = legalCnt;
          useCs_nxt = useCs;
          pulse_nxt = '0;
          if (csN_r) begin
            csN_nxt = 1'b0;
            state_nxt = ast_pkg::AST_H_SETUP;
          end else begin
            state_nxt = ast_pkg::AST_H_WAIT_EOC;
          end
        end
      end
      ast_pkg::AST_H_SETUP: begin
        if (timer_r == SETUP_LAST) begin
          timer_nxt = '0;
          state_nxt = ast_pkg::AST_H_WAIT_EOC;
        end
      end
      ast_pkg::AST_H_WAIT_EOC: begin
        // let a falling end-of-conversion reach us before trusting it
        if (timer_r >= EOC_LAST) begin
          timer_nxt = timer_r;
        end
        if (timer_r >= EOC_LAST && eocHigh) begin
          timer_nxt = '0;
          addrBit_nxt = addrSh_r[ast_pkg::ADDR_W-1];
          addrSh_nxt = {addrSh_r[ast_pkg::ADDR_W-2:0], 1'b0};
          state_nxt = ast_pkg::AST_H_LOW;
        end
      end
      ast_pkg::AST_H_LOW: begin
        if (timerHalf) begin
          timer_nxt = '0;
          ioClk_nxt = 1'b1;
          state_nxt = ast_pkg::AST_H_HIGH;
        end
      end
      ast_pkg::AST_H_HIGH: begin
        if (timerHalf) begin
          timer_nxt = '0;
          ioClk_nxt = 1'b0;
          if (rxTake) begin
            rx_nxt = {rx_r[ast_pkg::RES_W-2:0], datS3_r};
          end
          pulse_nxt = pulse_r + 1'b1;
          if (lastPulse) begin
            state_nxt = ast_pkg::AST_H_END;
          end else begin
            addrBit_nxt = addrSh_r[ast_pkg::ADDR_W-1];
            addrSh_nxt = {addrSh_r[ast_pkg::ADDR_W-2:0], 1'b0};
            state_nxt = ast_pkg::AST_H_LOW;
          end
        end
      end
      ast_pkg::AST_H_END: begin
        addrBit_nxt = 1'b0;
        if (useCs_r) begin
          csN_nxt = 1'b1;
        end
        // high select must be held long enough for the device to see it
        if (!useCs_r || timer_r == SETUP_LAST) begin
          result_nxt = rx_r;
          valid_nxt = 1'b1;
          timer_nxt = '0;
          state_nxt = ast_pkg::AST_H_IDLE;
        end
      end
      default: state_nxt = ast_pkg::AST_H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      eocS1_r <= 1'b0;
      eocS2_r <= 1'b0;
      eocS3_r <= 1'b0;
      datS1_r <= 1'b0;
      datS2_r <= 1'b0;
      datS3_r <= 1'b0;
    end else if (clkEn) begin
      eocS1_r <= link.eoc;
      eocS2_r <= eocS1_r;
      eocS3_r <= eocS2_r;
      datS1_r <= link.dataOut;
      datS2_r <= datS1_r;
      datS3_r <= datS2_r;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= ast_pkg::AST_H_IDLE;
      timer_r <= '0;
      csN_r <= 1'b1;
      ioClk_r <= 1'b0;
      addrSh_r <= '0;
      addrBit_r <= 1'b0;
      pulse_r <= '0;
      target_r <= ast_pkg::XFER_SHORT;
      useCs_r <= 1'b1;
      rx_r <= '0;
      result_r <= ast_pkg::RESULT_RST;
      valid_r <= 1'b0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      csN_r <= csN_nxt;
      ioClk_r <= ioClk_nxt;
      addrSh_r <= addrSh_nxt;
      addrBit_r <= addrBit_nxt;
      pulse_r <= pulse_nxt;
      target_r <= target_nxt;
      useCs_r <= useCs_nxt;
      rx_r <= rx_nxt;
      result_r <= result_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign link.csN = csN_r;
  assign link.ioClk = ioClk_r;
  assign link.addrBit = addrBit_r;
  assign ready = state_r == ast_pkg::AST_H_IDLE;
  assign result = result_r;
  assign resultValid = valid_r;
endmodule
`default_nettype wire

/* verification/ast_link_asserts.sv */
// Purpose: protocol checks on the converter serial link
// Assumes: link signals sampled on the host reference clock
// Notes: pulse counts restart when select drops or a result is ready
`timescale 1ns/1ps
`default_nettype none
module ast_link_asserts #(
  parameter int unsigned QUAL_CYC = 8,
  parameter int unsigned CONV_CYC = 40
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic csN,
  input wire logic ioClk,
  input wire logic addrBit,
  input wire logic dataOut,
  input wire logic dataOutEn,
  input wire logic eoc
);
  localparam int CONV_LO = CONV_CYC - 2;
  localparam int CONV_HI = CONV_CYC + 2;
  localparam int QUAL_ON = QUAL_CYC + 8;
  logic [7:0] lowCnt_r, highCnt_r, eocLowCnt_r;
  logic [4:0] riseCnt_r, fallCnt_r;
  logic ioClk_r, eoc_r;
  // counts restart per frame so pulse totals stay per transfer
  wire frameClr = !dataOutEn || (eoc && !eoc_r);
  wire ioRise = ioClk && !ioClk_r;
  wire ioFall = !ioClk && ioClk_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lowCnt_r <= 8'h00;
      highCnt_r <= 8'h00;
      eocLowCnt_r <= 8'h00;
      riseCnt_r <= 5'h00;
      fallCnt_r <= 5'h00;
      ioClk_r <= 1'b0;
      eoc_r <= 1'b1;
    end else begin
      ioClk_r <= ioClk;
      eoc_r <= eoc;
      lowCnt_r <= csN ? 8'h00 : lowCnt_r + {7'h00, lowCnt_r != 8'hff};
      highCnt_r <= !csN ? 8'h00 : highCnt_r + {7'h00, highCnt_r != 8'hff};
      eocLowCnt_r <= eoc ? 8'h00 :
        eocLowCnt_r + {7'h00, eocLowCnt_r != 8'hff};
      riseCnt_r <= frameClr ? 5'h00 : riseCnt_r + {4'h0, ioRise};
      fallCnt_r <= frameClr ? 5'h00 : fallCnt_r + {4'h0, ioFall};
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence tenth_fall;
    $fell(ioClk) && fallCnt_r == 5'h09;
  endsequence
  sequence conv_start;
    ##[1:10] $fell(eoc);
  endsequence
  property p_conv_after_tenth;
    tenth_fall |-> conv_start;
  endproperty
  a_qual_before_drive: assert property ($rose(dataOutEn) |->
    lowCnt_r >= QUAL_CYC) else $error("select driven before qualified");
  a_qual_drive_on: assert property (lowCnt_r == QUAL_ON |->
    dataOutEn) else $error("qualified select not taken");
  a_release_drop: assert property (highCnt_r == QUAL_ON |->
    !dataOutEn) else $error("select release not taken in time");
  a_release_persist: assert property ($fell(dataOutEn) |->
    highCnt_r >= QUAL_CYC) else $error("select release taken early");
  a_setup_quiet: assert property ($fell(csN) |-> !ioClk [*8])
    else $error("shift clock inside select setup");
  a_eoc_after_tenth: assert property (p_conv_after_tenth)
    else $error("conversion did not start after tenth pulse");
  a_eoc_only_tenth: assert property ($fell(eoc) |->
    fallCnt_r >= 5'h0a && fallCnt_r <= 5'h0b)
    else $error("conversion started at wrong pulse");
  a_conv_length: assert property ($rose(eoc) |->
    eocLowCnt_r >= CONV_LO && eocLowCnt_r <= CONV_HI)
    else $error("conversion length wrong");
  a_first_after_eoc: assert property ($rose(ioClk) &&
    riseCnt_r == 5'h00 |-> eoc)
    else $error("first pulse before result ready");
  a_long_resync: assert property ($rose(eoc) && riseCnt_r != 5'h00 |->
    riseCnt_r >= 5'h0a && riseCnt_r <= 5'h10)
    else $error("pulse count wrong at conversion end");
  a_pulse_limit: assert property (riseCnt_r <= 5'h10)
    else $error("more than sixteen pulses in a frame");
  a_idle_data_low: assert property (!dataOutEn |-> !dataOut)
    else $error("data driven while select not qualified");
  a_addr_steady: assert property ($rose(ioClk) |-> $stable(addrBit))
    else $error("address changed at shift clock rise");
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Purpose: end to end transfers between host port and converter
// Assumes: short qualification and conversion counts for run time
// Notes: each transfer returns the code of the one before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int QUAL = 8;
  localparam int CONV = 40;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic useCs = 1'b1;
  logic [ast_pkg::ADDR_W-1:0] addrIn = 4'h0;
  logic [ast_pkg::CNT_W-1:0] clkCount = 5'h0b;
  logic [ast_pkg::RES_W-1:0] convValue = 10'h000;
  logic [ast_pkg::ADDR_W-1:0] chanSel;
  logic sampleWin, convBusy, ready, resultValid;
  logic [ast_pkg::RES_W-1:0] lastResult, result, prevCode;
  logic [3:0] addrTab [12] = '{4'hb, 4'hc, 4'hd, 4'h3, 4'h0, 4'ha,
    4'he, 4'h7, 4'h5, 4'hf, 4'h2, 4'h1};
  logic [4:0] cntTab [12] = '{5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10,
    5'h03, 5'h0a, 5'h10, 5'h14, 5'h05, 5'h14};
  logic csTab [12] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
    1'b0, 1'b0, 1'b0, 1'b1};
  int errors = 0;
  int check_count = 0;
  int winCnt = 0;
  int busyCnt = 0;
  logic [3:0] winSel = 4'h0;
  ast_link_if link ();
  ast_device #(.QUAL_CYC(QUAL), .CONV_CYC(CONV)) i_ast_device (
    .ref_clk(ref_clk), .reset(reset), .clkEn(1'b1), .link(link.device),
    .convValue(convValue), .chanSel(chanSel), .sampleWin(sampleWin),
    .lastResult(lastResult), .convBusy(convBusy));
  ast_host #(.SETUP_CYC(QUAL + 8)) i_ast_host (
    .ref_clk(ref_clk), .reset(reset), .clkEn(1'b1), .link(link.host),
    .start(start), .addrIn(addrIn), .clkCount(clkCount), .useCs(useCs),
    .ready(ready), .result(result), .resultValid(resultValid));
  ast_link_asserts #(.QUAL_CYC(QUAL), .CONV_CYC(CONV)) i_ast_link_asserts (
    .ref_clk(ref_clk), .reset(reset), .csN(link.csN), .ioClk(link.ioClk),
    .addrBit(link.addrBit), .dataOut(link.dataOut),
    .dataOutEn(link.dataOutEn), .eoc(link.eoc));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // counters restart at each start; a missing window leaves ~address
  always @(posedge ref_clk) begin
    if (start === 1'b1) begin
      winCnt <= 0;
      busyCnt <= 0;
      winSel <= ~addrIn;
    end else begin
      if (sampleWin === 1'b1) begin
        winCnt <= winCnt + 1;
        winSel <= chanSel;
      end
      if (convBusy === 1'b1) busyCnt <= busyCnt + 1;
    end
  end
  task automatic complete_run();
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // sel 0 ready, 1 result pulse, 2 conversion done
  task automatic wait_for(input int sel);
    for (int i = 0; i < 4000; i++) begin
      @(negedge ref_clk);
      if ((sel == 0 && ready === 1'b1) || (sel == 1 && resultValid === 1'b1)
        || (sel == 2 && link.eoc === 1'b1)) return;
    end
    errors++;
    complete_run();
  endtask
  function automatic logic [9:0] code_of(input logic [3:0] a,
    input logic [9:0] v);
    if (a == ast_pkg::SELF_MID) return ast_pkg::CODE_MID;
    if (a == ast_pkg::SELF_ZERO) return ast_pkg::CODE_ZERO;
    if (a == ast_pkg::SELF_FULL) return ast_pkg::CODE_FULL;
    return v;
  endfunction
  task automatic run(input logic [3:0] a, input logic [4:0] n,
    input logic cs);
    logic [9:0] v;
    v = {a, 6'h2b} ^ 10'h155;
    wait_for(0);
    @(posedge ref_clk);
    start <= 1'b1;
    addrIn <= a;
    clkCount <= n;
    useCs <= cs;
    convValue <= v;
    @(posedge ref_clk);
    start <= 1'b0;
    wait_for(1);
    check(result, prevCode);
    // end-of-conversion may lag the last pulse by a few cycles
    repeat (8) @(negedge ref_clk);
    wait_for(2);
    check(lastResult, code_of(a, v));
    check(winCnt[9:0], 10'h018);
    check({6'h00, winSel}, {6'h00, a});
    check(busyCnt[9:0], 10'(CONV));
    prevCode = code_of(a, v);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    prevCode = ast_pkg::RESULT_RST;
    for (int k = 0; k < 12; k++) run(addrTab[k], cntTab[k], csTab[k]);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    prevCode = ast_pkg::RESULT_RST;
    run(4'hd, 5'h0b, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
